// ### rtl/sticky_flag.sv
// One sticky event flag with set priority over clear.
// Assumes set and clear are single-cycle strobes on mclk.
`timescale 1ns/1ps
module sticky_flag (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  // An event in the same cycle as a clear must not be lost.
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule : sticky_flag

// ### rtl/timer_irq.sv
// Interrupt enable and status flags of a general-purpose timer.
// Assumes timer strobes and register port are synchronous to mclk.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "timer_irq_map.svh"
module timer_irq (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire timer_irq_pkg::bus_req_s bus_req,
  input  wire timer_irq_pkg::timer_evt_s evt,
  output logic [15:0]                  rd_data,
  output logic                         update_event,
  output logic                         irq
);

  // ==========================================================================
  // Helpers

  // Places the four internal flags at their register bit positions.
  function automatic logic [15:0] to_reg(input timer_irq_pkg::flag_vec_t v);
    logic [15:0] r;
    r = 16'h0000;
    r[`TIRQ_BIT_UPD] = v[0];
    r[`TIRQ_BIT_CH1] = v[1];
    r[`TIRQ_BIT_CH2] = v[2];
    r[`TIRQ_BIT_TRG] = v[3];
    return r;
  endfunction : to_reg

  // Gathers the four register bits back into internal order.
  function automatic timer_irq_pkg::flag_vec_t from_reg(input logic [15:0] r);
    return {r[`TIRQ_BIT_TRG], r[`TIRQ_BIT_CH2], r[`TIRQ_BIT_CH1],
            r[`TIRQ_BIT_UPD]};
  endfunction : from_reg

  // ==========================================================================
  // Address decode
  // Byte addresses are compared in full, so the registers have no aliases and
  // a stray write to an unmapped address does nothing.

  logic                      wr_ctrl;
  logic                      wr_ien;
  logic                      wr_sts;
  logic                      wr_egen;
  timer_irq_pkg::flag_vec_t  wr_bits;

  assign wr_ctrl = bus_req.wr && (bus_req.addr == `TIRQ_OFS_CTRL);
  assign wr_ien  = bus_req.wr && (bus_req.addr == `TIRQ_OFS_IEN);
  assign wr_sts  = bus_req.wr && (bus_req.addr == `TIRQ_OFS_STS);
  assign wr_egen = bus_req.wr && (bus_req.addr == `TIRQ_OFS_EGEN);
  assign wr_bits = from_reg(bus_req.wdata);

  // ==========================================================================
  // Control register
  // Only the four bits that gate flag setting are kept; the rest read as zero,
  // which keeps the register small at the cost of a partial control word.

  logic [15:0] ctrl_r;
  logic        update_disable;
  logic        update_source_select;
  logic        ch1_is_input;
  logic        ch2_is_input;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= `TIRQ_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_r <= 16'h0000;
      ctrl_r[`TIRQ_BIT_UDIS]   <= bus_req.wdata[`TIRQ_BIT_UDIS];
      ctrl_r[`TIRQ_BIT_USRC]   <= bus_req.wdata[`TIRQ_BIT_USRC];
      ctrl_r[`TIRQ_BIT_CH1_IN] <= bus_req.wdata[`TIRQ_BIT_CH1_IN];
      ctrl_r[`TIRQ_BIT_CH2_IN] <= bus_req.wdata[`TIRQ_BIT_CH2_IN];
    end
  end

  assign update_disable       = ctrl_r[`TIRQ_BIT_UDIS];
  assign update_source_select = ctrl_r[`TIRQ_BIT_USRC];
  assign ch1_is_input         = ctrl_r[`TIRQ_BIT_CH1_IN];
  assign ch2_is_input         = ctrl_r[`TIRQ_BIT_CH2_IN];

  // ==========================================================================
  // Interrupt enable register

  timer_irq_pkg::flag_vec_t ien_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ien_r <= from_reg(`TIRQ_RST_IEN);
    end else if (wr_ien) begin
      ien_r <= wr_bits;
    end
  end

  // ==========================================================================
  // Event generation strobes
  // The write itself is the pulse, so the register always reads back zero.

  logic update_generate;
  logic sw_ch1_event;
  logic sw_ch2_event;
  logic sw_trig_event;

  assign update_generate = wr_egen && bus_req.wdata[`TIRQ_BIT_UPD];
  assign sw_ch1_event    = wr_egen && bus_req.wdata[`TIRQ_BIT_CH1];
  assign sw_ch2_event    = wr_egen && bus_req.wdata[`TIRQ_BIT_CH2];
  assign sw_trig_event   = wr_egen && bus_req.wdata[`TIRQ_BIT_TRG];

  // ==========================================================================
  // Update event sources
  // Every source is gated by update_disable. Software and trigger sources
  // raise the flag only while update_source_select is clear; they still
  // reload the counter otherwise, so the event leaves but the flag stays.

  logic upd_from_overrun;
  logic upd_from_sw;
  logic upd_from_trig;
  logic upd_event_c;
  logic upd_flag_set;

  assign upd_from_overrun = evt.rep_overrun && !update_disable;
  assign upd_from_sw      = update_generate && !update_disable;
  assign upd_from_trig    = evt.trig_reinit && !update_disable;
  assign upd_event_c      = upd_from_overrun || upd_from_sw || upd_from_trig;
  assign upd_flag_set     = upd_from_overrun
                         || ((upd_from_sw || upd_from_trig)
                             && !update_source_select);

  always_ff @(posedge mclk) begin
    if (rst) begin
      update_event <= 1'b0;
    end else begin
      update_event <= upd_event_c;
    end
  end

  // ==========================================================================
  // Channel and trigger flag sources

  logic ch1_set;
  logic ch2_set;
  logic trg_set;

  assign ch1_set = (!ch1_is_input && evt.ch1_match)
                || (ch1_is_input && evt.ch1_capture)
                || sw_ch1_event;
  assign ch2_set = (!ch2_is_input && evt.ch2_match)
                || (ch2_is_input && evt.ch2_capture)
                || sw_ch2_event;
  assign trg_set = evt.trig_event || sw_trig_event;

  // ==========================================================================
  // Status flags
  // Writing zero clears a flag, writing one leaves it alone. A channel flag
  // also clears when its capture/compare register is read.

  timer_irq_pkg::flag_vec_t flag_set;
  timer_irq_pkg::flag_vec_t flag_clr;
  timer_irq_pkg::flag_vec_t flags;

  assign flag_set = {trg_set, ch2_set, ch1_set, upd_flag_set};
  assign flag_clr[0] = wr_sts && !wr_bits[0];
  assign flag_clr[1] = (wr_sts && !wr_bits[1]) || evt.ch1_reg_read;
  assign flag_clr[2] = (wr_sts && !wr_bits[2]) || evt.ch2_reg_read;
  assign flag_clr[3] = wr_sts && !wr_bits[3];

  for (genvar i = 0; i < 4; i++) begin : g_flag
    sticky_flag u_flag (
      .mclk (mclk),
      .rst  (rst),
      .set  (flag_set[i]),
      .clr  (flag_clr[i]),
      .q    (flags[i])
    );
  end

  // ==========================================================================
  // Interrupt output
  // Registering irq gives a glitch-free line; computing it from the next
  // state keeps it in step with the flags instead of a cycle behind.

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_nxt_view(flag_set, flag_clr, flags) & ien_nxt_view());
    end
  end

  // Next flag state, so the registered irq tracks the flags without lag.
  function automatic timer_irq_pkg::flag_vec_t flags_nxt_view(
    input timer_irq_pkg::flag_vec_t s,
    input timer_irq_pkg::flag_vec_t c,
    input timer_irq_pkg::flag_vec_t q
  );
    return s | (q & ~c);
  endfunction : flags_nxt_view

  function automatic timer_irq_pkg::flag_vec_t ien_nxt_view();
    return wr_ien ? wr_bits : ien_r;
  endfunction : ien_nxt_view

  // ==========================================================================
  // Read port
  // Data stand for exactly one cycle after the read strobe; unmapped
  // addresses and the write-only event register read as zero.

  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (bus_req.addr)
      `TIRQ_OFS_CTRL: rd_mux = ctrl_r;
      `TIRQ_OFS_IEN:  rd_mux = to_reg(ien_r);
      `TIRQ_OFS_STS:  rd_mux = to_reg(flags);
      default:        rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else if (bus_req.rd) begin
      rd_data <= rd_mux;
    end else begin
      rd_data <= 16'h0000;
    end
  end

  // ==========================================================================
  // Assertions
  // All checks run on mclk and are off while reset is high. Clear checks
  // leave out cycles with a set event, since a set always wins.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_read_ien;
    bus_req.rd && bus_req.addr == `TIRQ_OFS_IEN;
  endsequence

  sequence s_write_ien;
    wr_ien;
  endsequence

  sequence s_sts_keep_write;
    wr_sts && wr_bits[3] && flags[3] && !evt.trig_event;
  endsequence

  sequence s_upd_clear_write;
    wr_sts && !wr_bits[0] && !upd_flag_set;
  endsequence

  sequence s_trg_clear_write;
    wr_sts && !wr_bits[3] && !trg_set;
  endsequence

  a_ien_readback: assert property (
    s_write_ien ##1 s_read_ien |=> rd_data == to_reg($past(ien_r)))
    else $error("enable register readback mismatch");

  a_reset_zero: assert property (
    $fell(rst) |-> (ien_r == 4'h0 && flags == 4'h0 && !irq))
    else $error("enable or status not zero after reset");

  a_update_overrun: assert property (
    evt.rep_overrun && !update_disable |=> flags[0] && update_event)
    else $error("overrun did not raise update flag");

  a_update_blocked: assert property (
    update_disable && !flags[0] |=> !flags[0])
    else $error("update flag set while updates disabled");

  a_update_sw: assert property (
    update_generate && !update_disable && !update_source_select
      |=> flags[0])
    else $error("update generate did not set update flag");

  a_update_trig: assert property (
    evt.trig_reinit && !update_disable && !update_source_select
      |=> flags[0] ##1 (flags[0] || $past(flag_clr[0])))
    else $error("trigger reinit did not set update flag");

  a_ch1_match: assert property (
    evt.ch1_match && !ch1_is_input |=> flags[1])
    else $error("channel 1 match did not set flag");

  a_ch1_capture: assert property (
    evt.ch1_capture && ch1_is_input |=> flags[1])
    else $error("channel 1 capture did not set flag");

  a_ch1_read_clear: assert property (
    evt.ch1_reg_read && !ch1_set |=> !flags[1])
    else $error("channel 1 register read did not clear flag");

  a_ch2_read_clear: assert property (
    evt.ch2_reg_read && !ch2_set |=> !flags[2])
    else $error("channel 2 register read did not clear flag");

  a_trig_flag: assert property (
    evt.trig_event |=> flags[3])
    else $error("trigger event did not set trigger flag");

  a_sts_one_keep: assert property (
    s_sts_keep_write |=> flags[3])
    else $error("writing one changed a status flag");

  a_irq_follow: assert property (
    irq == |(flags & ien_r))
    else $error("interrupt output disagrees with flags and enables");

  a_ch2_match: assert property (
    evt.ch2_match && !ch2_is_input |=> flags[2])
    else $error("channel 2 match did not set flag");

  a_ch2_capture: assert property (
    evt.ch2_capture && ch2_is_input |=> flags[2])
    else $error("channel 2 capture did not set flag");

  a_ch1_mode_gate: assert property (
    ch1_is_input && evt.ch1_match && !evt.ch1_capture && !sw_ch1_event
      && !flags[1] |=> !flags[1])
    else $error("channel 1 match set flag in input mode");

  a_update_clear: assert property (
    s_upd_clear_write |=> !flags[0])
    else $error("writing zero did not clear update flag");

  a_trig_clear: assert property (
    s_trg_clear_write |=> !flags[3])
    else $error("writing zero did not clear trigger flag");

  a_update_src_sel: assert property (
    update_generate && !update_disable && update_source_select
      && !evt.rep_overrun && !flags[0] |=> update_event && !flags[0])
    else $error("update with source select set changed the update flag");

  a_irq_masked: assert property (
    ien_r == 4'h0 && !wr_ien |=> !irq)
    else $error("interrupt raised with every enable clear");

  a_trig_irq: assert property (
    evt.trig_event && ien_r[3] && !wr_ien |=> irq)
    else $error("enabled trigger event did not raise interrupt");

endmodule : timer_irq

// ### rtl/timer_irq_map.svh
// Register offsets, field positions, reset values and strobe layout for the
// timer interrupt enable and status block.
// Assumes a 16-bit register port with byte addresses on an 8-bit address.
//
// Operation
// - Enable bits 0,1,2,6: update, ch1, ch2, trigger.
// - Enable and status registers reset to zero.
// - Update flag bit 0 set on update event.
// - Repetition overrun sets update flag unless disabled.
// - Update-generate write sets flag when select, disable zero.
// - Trigger reinit sets flag when select, disable zero.
// - Output channel 1 compare match sets bit 1.
// - Input channel 1 capture sets bit 1.
// - Channel 1 flag cleared by zero-write or read.
// - Channel 2 flag, bit 2, mirrors channel 1.
// - Trigger event sets flag bit 6; zero-write clears.
`ifndef TIMER_IRQ_MAP_SVH
`define TIMER_IRQ_MAP_SVH

// ==========================================================================
// Register offsets
`define TIRQ_OFS_CTRL      8'h00
`define TIRQ_OFS_IEN       8'h0C
`define TIRQ_OFS_STS       8'h10
`define TIRQ_OFS_EGEN      8'h14

// ==========================================================================
// Reset values
`define TIRQ_RST_IEN       16'h0000
`define TIRQ_RST_STS       16'h0000
`define TIRQ_RST_CTRL      16'h0000

// ==========================================================================
// Field positions, shared by enable, status and event generation
`define TIRQ_BIT_UPD       0
`define TIRQ_BIT_CH1       1
`define TIRQ_BIT_CH2       2
`define TIRQ_BIT_TRG       6

// ==========================================================================
// Control register fields
`define TIRQ_BIT_UDIS      1
`define TIRQ_BIT_USRC      2
`define TIRQ_BIT_CH1_IN    4
`define TIRQ_BIT_CH2_IN    5

`endif

// ### rtl/timer_irq_pkg.sv
// Types shared by the timer interrupt enable and status block.
// Assumes one clock domain; all structs travel on the timer bus clock.
package timer_irq_pkg;

  // ========================================================================
  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  // ========================================================================
  // Single-cycle strobes from the rest of the timer
  typedef struct packed {
    logic rep_overrun;
    logic trig_reinit;
    logic trig_event;
    logic ch1_match;
    logic ch1_capture;
    logic ch1_reg_read;
    logic ch2_match;
    logic ch2_capture;
    logic ch2_reg_read;
  } timer_evt_s;

  // Flag order inside the block: update, channel 1, channel 2, trigger.
  typedef logic [3:0] flag_vec_t;

endpackage : timer_irq_pkg

// ### test/timer_irq_test.sv
// Self-checking bench for the timer interrupt enable and status block.
// Assumes the block is the only device on its register port and that the bench
// drives every timer strobe; a cycle model of the registers runs beside it.
`timescale 1ns/1ps
`include "timer_irq_map.svh"
module timer_irq_test;
  logic                      mclk;
  logic                      rst;
  timer_irq_pkg::bus_req_s   bus_req;
  timer_irq_pkg::timer_evt_s evt;
  logic [15:0]               rd_data;
  logic                      update_event;
  logic                      irq;
  int                        errors;
  int                        checks;
  logic [15:0]               m_ien;
  logic [15:0]               m_sts;
  logic [15:0]               m_rd;
  logic                      m_ud;
  logic                      m_usrc;
  logic                      m_in1;
  logic                      m_in2;
  logic                      m_upd;
  logic                      m_irq;
  logic                      live;
  logic [7:0]                addrs [5];
  logic [15:0]               modes [4];

  timer_irq i_dut (
    .mclk         (mclk),
    .rst          (rst),
    .bus_req      (bus_req),
    .evt          (evt),
    .rd_data      (rd_data),
    .update_event (update_event),
    .irq          (irq)
  );

  // ==========================================================================
  // Clock, comparison and verdict
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // Reference model, sampled at the same edge as the design.
  always @(posedge mclk) begin : model
    logic        sw;
    logic        s_upd;
    logic        s_c1;
    logic        s_c2;
    logic        s_trg;
    logic [15:0] nx;
    live = 1'b1;
    if (rst) begin
      {m_ien, m_sts, m_rd} = '0;
      {m_ud, m_usrc, m_in1, m_in2, m_upd, m_irq} = '0;
    end else begin
      sw = bus_req.wr && bus_req.addr == `TIRQ_OFS_EGEN;
      m_rd = 16'h0000;
      if (bus_req.rd && bus_req.addr == `TIRQ_OFS_IEN) m_rd = m_ien;
      if (bus_req.rd && bus_req.addr == `TIRQ_OFS_STS) m_rd = m_sts;
      if (bus_req.rd && bus_req.addr == `TIRQ_OFS_CTRL)
        m_rd = {10'h000, m_in2, m_in1, 1'b0, m_usrc, m_ud, 1'b0};
      m_upd = !m_ud && (evt.rep_overrun || evt.trig_reinit || (sw && bus_req.wdata[0]));
      s_upd = !m_ud && (evt.rep_overrun
              || (!m_usrc && (evt.trig_reinit || (sw && bus_req.wdata[0]))));
      s_c1 = (m_in1 ? evt.ch1_capture : evt.ch1_match) || (sw && bus_req.wdata[1]);
      s_c2 = (m_in2 ? evt.ch2_capture : evt.ch2_match) || (sw && bus_req.wdata[2]);
      s_trg = evt.trig_event || (sw && bus_req.wdata[6]);
      nx = m_sts;
      if (bus_req.wr && bus_req.addr == `TIRQ_OFS_STS) nx = nx & bus_req.wdata;
      if (evt.ch1_reg_read) nx[1] = 1'b0;
      if (evt.ch2_reg_read) nx[2] = 1'b0;
      m_sts = nx | {9'h000, s_trg, 3'h0, s_c2, s_c1, s_upd};
      if (bus_req.wr && bus_req.addr == `TIRQ_OFS_IEN) m_ien = bus_req.wdata & 16'h0047;
      if (bus_req.wr && bus_req.addr == `TIRQ_OFS_CTRL) begin
        {m_in2, m_in1} = bus_req.wdata[5:4];
        {m_usrc, m_ud} = bus_req.wdata[2:1];
      end
      m_irq = |(m_sts & m_ien);
    end
  end

  // Outputs are settled half a period after the launching edge.
  always @(negedge mclk) begin
    if (live === 1'b1) begin
      check("rd_data", rd_data, m_rd);
      check("irq", 16'(irq), 16'(m_irq));
      check("update_event", 16'(update_event), 16'(m_upd));
    end
  end

  // ==========================================================================
  // Stimulus
  task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                     input logic [15:0] d, input logic [8:0] e);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
    evt     <= timer_irq_pkg::timer_evt_s'(e);
  endtask : cyc

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    bus_req <= '0;
    evt <= '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  initial begin
    #100000;
    errors++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    bus_req = '0;
    evt = '0;
    live = 1'b0;
    errors = 0;
    checks = 0;
    addrs = '{`TIRQ_OFS_CTRL, `TIRQ_OFS_IEN, `TIRQ_OFS_STS, `TIRQ_OFS_EGEN, 8'h20};
    modes = '{16'h0000, 16'h0002, 16'h0004, 16'h0030};
    void'($urandom(32'h14A632ED));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, then enable bits with reserved bits written as ones.
    cyc(1'b0, 1'b1, `TIRQ_OFS_IEN, 16'h0000, 9'h000);
    cyc(1'b0, 1'b1, `TIRQ_OFS_STS, 16'h0000, 9'h000);
    cyc(1'b1, 1'b0, `TIRQ_OFS_IEN, 16'hFFFF, 9'h000);
    cyc(1'b0, 1'b1, `TIRQ_OFS_IEN, 16'h0000, 9'h000);
    // Every event strobe and software event in each control mode.
    foreach (modes[m]) begin
      cyc(1'b1, 1'b0, `TIRQ_OFS_CTRL, modes[m], 9'h000);
      cyc(1'b0, 1'b1, `TIRQ_OFS_CTRL, 16'h0000, 9'h000);
      for (int e = 0; e < 10; e++) begin
        if (e == 9) begin
          cyc(1'b1, 1'b0, `TIRQ_OFS_EGEN, 16'h0047, 9'h000);
        end else begin
          cyc(1'b0, 1'b0, 8'h00, 16'h0000, 9'(1 << e));
        end
        cyc(1'b0, 1'b1, `TIRQ_OFS_STS, 16'h0000, 9'h000);
        cyc(1'b1, 1'b0, `TIRQ_OFS_STS, 16'hFFFF, 9'h000);
        cyc(1'b1, 1'b1 ^ 1'b1, `TIRQ_OFS_STS, 16'h0000, 9'h000);
      end
    end
    // Random traffic on the port and the strobes, back to back.
    for (int n = 0; n < 3000; n++) begin
      int k;
      k = $urandom % 6;
      cyc(k == 2, k > 3, addrs[$urandom % 5],
          16'($urandom), 9'($urandom & $urandom & $urandom));
      if (n == 1500) do_reset();
    end
    cyc(1'b0, 1'b1, `TIRQ_OFS_STS, 16'h0000, 9'h000);
    cyc(1'b0, 1'b0, 8'h00, 16'h0000, 9'h000);
    repeat (3) @(posedge mclk);
    summarize();
  end
endmodule : timer_irq_test
